// ===== rtl/adc_conversion_control.sv
// How it works
// - the selected shared pin is taken from the port logic as analog input
// - port data and direction writes do not reach the selected pin
// - port reads of the selected pin return zero
// - one-hot mux routes at most one of 24 channels to the converter
// - upper reference gives 3ff, lower gives 000, linear between
// - every status/control write with a channel code other than 31 starts a new conversion
// - a conversion takes 16 converter clock cycles
// - continuous mode reconverts and overwrites until its bit clears
// - without interrupts the done flag sets per conversion until result read
// - single mode does one conversion per status/control write
// - two-bit justify field picks one of four result formats
// - left format: top eight bits high byte, low two on low byte top
// - high byte read locks storing until low byte is read
// - right format: top two bits low of high byte, rest low byte
// - signed left format is left format with the top bit inverted
// - truncation format: top eight bits in low byte, no lock
// - with interrupt enable an interrupt replaces the done flag
// - converter keeps running in wait, its interrupt can wake the cpu
// - stop aborts the conversion, conversions resume after stop
// - channel codes 0-23 pins, 29 upper, 30 lower, 31 power off
// - done reads zero with interrupts; pending irq clears on read/write
// - prescaler divides by 1,2,4,8 or 16; source bus or oscillator
// - justify codes 00 trunc, 01 right, 10 left, 11 signed; reset 01
`timescale 1ns/1ps
`default_nettype none
`include "adc_params.svh"
module adc_conversion_control #(
   parameter int NUM_CH = 24,
   parameter int RES_BITS = 10
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire adc_pkg::bus_req_t bus_req,
   output logic [7:0] rd_data,
   // clock source and low-power state
   input wire logic osc_tick,
   input wire logic stop_mode,
   // port logic side
   input wire logic [NUM_CH-1:0] port_out_data,
   input wire logic [NUM_CH-1:0] port_dir,
   output logic [NUM_CH-1:0] port_read_data,
   // pads
   input wire logic [NUM_CH-1:0] pin_in,
   output logic [NUM_CH-1:0] pin_out,
   output logic [NUM_CH-1:0] pin_oe,
   // analog front end
   output logic [NUM_CH-1:0] analog_select,
   output logic upper_ref_select,
   output logic lower_ref_select,
   output logic converter_on,
   output logic [RES_BITS-1:0] dac_code,
   input wire logic comp_above,
   // completion
   output logic conv_irq
);
   import adc_pkg::*;

   if (NUM_CH != 24 || RES_BITS != 10) begin : g_bad_cfg
      $error("channel count must be 24 and resolution 10 bits");
   end

   ////////////////////////////////////////////////////////////////////
   // last prescaler count; every code with the top bit set divides by 16
   function automatic logic [3:0] div_last(input logic [2:0] code);
      begin
         if (code[2]) begin
            div_last = 4'hf;
         end else begin
            div_last = 4'((5'h01 << code[1:0]) - 5'h01);
         end
      end
   endfunction

   function automatic logic powered(input logic [4:0] code);
      begin
         powered = code != `CH_POWER_OFF;
      end
   endfunction

   function automatic result_t format_result(input justify_t mode,
                                             input logic [9:0] r);
      result_t f;
      begin
         f = '0;
         case (mode)
            JUST_TRUNC8: f.low = r[9:2];
            JUST_RIGHT: begin
               f.high = {6'h00, r[9:8]};
               f.low = r[7:0];
            end
            JUST_LEFT: begin
               f.high = r[9:2];
               f.low = {r[1:0], 6'h00};
            end
            JUST_LEFT_SIGNED: begin
               f.high = {~r[9], r[8:2]};
               f.low = {r[1:0], 6'h00};
            end
            default: f = '0;
         endcase
         format_result = f;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // registers
   logic ien_ff, nxt_ien;
   logic cont_ff, nxt_cont;
   logic [4:0] ch_ff, nxt_ch;
   logic [2:0] div_ff, nxt_div;
   logic src_ff, nxt_src;
   justify_t mode_ff, nxt_mode;
   logic done_ff, nxt_done;
   logic irq_ff, nxt_irq;
   logic lock_ff, nxt_lock;
   result_t res_ff, nxt_res;
   logic [7:0] rd_ff, nxt_rd;
   // converter
   conv_state_t st_ff, nxt_st;
   logic [3:0] step_ff, nxt_step;
   logic [3:0] pre_ff, nxt_pre;
   logic [9:0] sar_ff, nxt_sar;
   logic resume_ff, nxt_resume;
   // pins
   logic [NUM_CH-1:0] sel_ff, nxt_sel;
   logic [NUM_CH-1:0] pout_ff, nxt_pout;
   logic [NUM_CH-1:0] pin_oe_ff, nxt_pin_oe;
   logic [NUM_CH-1:0] prd_ff, nxt_prd;
   logic uref_ff, nxt_uref;
   logic lref_ff, nxt_lref;
   logic on_ff, nxt_on;

   logic wr_sc, rd_hi, rd_lo, adc_tick, src_tick, conv_end;
   logic [9:0] final_code;
   logic [3:0] bit_idx;

   always_comb begin
      wr_sc = bus_req.wr && bus_req.addr == `OFS_STATUS_CTRL;
      rd_hi = bus_req.rd && bus_req.addr == `OFS_RESULT_HIGH;
      rd_lo = bus_req.rd && bus_req.addr == `OFS_RESULT_LOW;
      src_tick = src_ff ? 1'b1 : osc_tick;
      adc_tick = src_tick && pre_ff == div_last(div_ff);
      // always 16 ticks: the prescaler restarts with each conversion except one resumed after stop
      conv_end = st_ff == ST_CONV && adc_tick &&
                 step_ff == 4'(`CONV_TICKS - 1);
      bit_idx = 4'(`CONV_TICKS - 1) - step_ff;
      final_code = sar_ff;
      if (!comp_above) begin
         final_code[0] = 1'b0;
      end
      // reference channels bypass the comparator and give the rail codes
      if (ch_ff == `CH_UPPER_REF) begin
         final_code = 10'h3ff;
      end else if (ch_ff == `CH_LOWER_REF) begin
         final_code = 10'h000;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register file, flags and conversion sequencer
   always_comb begin
      nxt_ien = ien_ff;
      nxt_cont = cont_ff;
      nxt_ch = ch_ff;
      nxt_div = div_ff;
      nxt_src = src_ff;
      nxt_mode = mode_ff;
      nxt_done = done_ff;
      nxt_irq = irq_ff;
      nxt_lock = lock_ff;
      nxt_res = res_ff;
      nxt_rd = 8'h00;
      nxt_st = st_ff;
      nxt_step = step_ff;
      nxt_sar = sar_ff;
      nxt_resume = resume_ff;
      nxt_pre = src_tick ? (adc_tick ? 4'h0 : pre_ff + 4'h1) : pre_ff;

      // reads; clears come first so a same-cycle set below wins
      if (bus_req.rd) begin
         case (bus_req.addr)
            `OFS_STATUS_CTRL: nxt_rd = {done_ff && !ien_ff, ien_ff,
                                        cont_ff, ch_ff};
            `OFS_RESULT_HIGH: nxt_rd = res_ff.high;
            `OFS_RESULT_LOW: nxt_rd = res_ff.low;
            `OFS_CLOCK_CFG: nxt_rd = {div_ff, src_ff, mode_ff, 2'b00};
            default: nxt_rd = 8'h00;
         endcase
      end
      if (rd_hi || rd_lo) begin
         nxt_done = 1'b0;
         nxt_irq = 1'b0;
      end
      if (rd_hi && mode_ff != JUST_TRUNC8) begin
         nxt_lock = 1'b1;
      end
      if (rd_lo) begin
         nxt_lock = 1'b0;
      end

      if (bus_req.wr) begin
         case (bus_req.addr)
            `OFS_STATUS_CTRL: begin
               nxt_ien = bus_req.wdata[`SC_IEN_BIT];
               nxt_cont = bus_req.wdata[`SC_CONT_BIT];
               nxt_ch = bus_req.wdata[`SC_CH_LSB +: 5];
               nxt_irq = 1'b0;
            end
            `OFS_CLOCK_CFG: begin
               nxt_div = bus_req.wdata[`CC_DIV_LSB +: 3];
               nxt_src = bus_req.wdata[`CC_SRC_BIT];
               nxt_mode = justify_t'(bus_req.wdata[`CC_MODE_LSB +: 2]);
            end
            default: ;
         endcase
      end

      // sequencer; runs on in wait, only stop or a status/control write with channel 31 halts it
      case (st_ff)
         ST_IDLE: ;
         ST_CONV: begin
            if (adc_tick) begin
               nxt_step = step_ff + 4'h1;
               if (step_ff == 4'(`SAMPLE_TICKS - 1)) begin
                  nxt_sar = 10'h200;
               end else if (step_ff >= 4'(`SAMPLE_TICKS)) begin
                  if (!comp_above) begin
                     nxt_sar[bit_idx] = 1'b0;
                  end
                  if (bit_idx != 4'h0) begin
                     nxt_sar[bit_idx - 4'h1] = 1'b1;
                  end
               end
            end
            if (conv_end) begin
               // results lost while the high byte read is pending;
               // a high read in this same cycle already holds the pair
               if (!(lock_ff || rd_hi) ||
                   mode_ff == JUST_TRUNC8) begin
                  nxt_res = format_result(mode_ff, final_code);
               end
               if (ien_ff) begin
                  nxt_irq = 1'b1;
               end else begin
                  nxt_done = 1'b1;
               end
               nxt_step = 4'h0;
               nxt_sar = 10'h000;
               nxt_st = cont_ff ? ST_CONV : ST_IDLE;
            end
         end
         default: nxt_st = ST_IDLE;
      endcase

      if (wr_sc) begin
         // a rewrite restarts from the first sample cycle
         nxt_step = 4'h0;
         nxt_sar = 10'h000;
         nxt_pre = 4'h0;
         nxt_st = powered(bus_req.wdata[`SC_CH_LSB +: 5])
                  ? ST_CONV : ST_IDLE;
      end
      // stop idles the converter but keeps pending flags for wake-up
      if (stop_mode) begin
         nxt_resume = resume_ff || st_ff == ST_CONV || nxt_st == ST_CONV;
         nxt_st = ST_IDLE;
         nxt_step = 4'h0;
         nxt_sar = 10'h000;
      end else if (resume_ff) begin
         nxt_resume = 1'b0;
         if (powered(ch_ff)) begin
            nxt_st = ST_CONV;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ien_ff <= 1'b0;
         cont_ff <= 1'b0;
         ch_ff <= `RST_CHANNEL;
         div_ff <= `RST_DIV;
         src_ff <= `RST_SRC;
         mode_ff <= justify_t'(`RST_MODE);
         done_ff <= 1'b0;
         irq_ff <= 1'b0;
         lock_ff <= 1'b0;
         res_ff <= '0;
         rd_ff <= 8'h00;
         st_ff <= ST_IDLE;
         step_ff <= 4'h0;
         pre_ff <= 4'h0;
         sar_ff <= 10'h000;
         resume_ff <= 1'b0;
      end else begin
         ien_ff <= nxt_ien;
         cont_ff <= nxt_cont;
         ch_ff <= nxt_ch;
         div_ff <= nxt_div;
         src_ff <= nxt_src;
         mode_ff <= nxt_mode;
         done_ff <= nxt_done;
         irq_ff <= nxt_irq;
         lock_ff <= nxt_lock;
         res_ff <= nxt_res;
         rd_ff <= nxt_rd;
         st_ff <= nxt_st;
         step_ff <= nxt_step;
         pre_ff <= nxt_pre;
         sar_ff <= nxt_sar;
         resume_ff <= nxt_resume;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin takeover and channel mux
   always_comb begin
      nxt_sel = '0;
      // codes 24 to 28 route no pin; their result is meaningless
      if (ch_ff < 5'(NUM_CH)) begin
         nxt_sel[ch_ff] = 1'b1;
      end
      // pads follow a channel change one clock late, like the select
      nxt_pout = port_out_data & ~nxt_sel;
      nxt_pin_oe = port_dir & ~nxt_sel;
      nxt_prd = pin_in & ~nxt_sel;
      nxt_uref = ch_ff == `CH_UPPER_REF;
      nxt_lref = ch_ff == `CH_LOWER_REF;
      nxt_on = powered(ch_ff);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         sel_ff <= '0;
         pout_ff <= '0;
         pin_oe_ff <= '0;
         prd_ff <= '0;
         uref_ff <= 1'b0;
         lref_ff <= 1'b0;
         on_ff <= 1'b0;
      end else begin
         sel_ff <= nxt_sel;
         pout_ff <= nxt_pout;
         pin_oe_ff <= nxt_pin_oe;
         prd_ff <= nxt_prd;
         uref_ff <= nxt_uref;
         lref_ff <= nxt_lref;
         on_ff <= nxt_on;
      end
   end

   // irq stays live in wait so it can wake the cpu
   assign conv_irq = irq_ff;
   assign rd_data = rd_ff;
   assign analog_select = sel_ff;
   assign upper_ref_select = uref_ff;
   assign lower_ref_select = lref_ff;
   assign converter_on = on_ff;
   assign dac_code = sar_ff;
   assign pin_out = pout_ff;
   assign pin_oe = pin_oe_ff;
   assign port_read_data = prd_ff;
endmodule
`default_nettype wire

// ===== rtl/adc_params.svh
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH
// register offsets on the 2-bit register port
`define OFS_STATUS_CTRL 2'h0
`define OFS_RESULT_HIGH 2'h1
`define OFS_RESULT_LOW 2'h2
`define OFS_CLOCK_CFG 2'h3
// status/control fields
`define SC_DONE_BIT 7
`define SC_IEN_BIT 6
`define SC_CONT_BIT 5
`define SC_CH_LSB 0
// clock configuration fields
`define CC_DIV_LSB 5
`define CC_SRC_BIT 4
`define CC_MODE_LSB 2
// reset values
`define RST_CHANNEL 5'h1f
`define RST_DIV 3'h0
`define RST_SRC 1'h0
`define RST_MODE 2'h1
// channel codes
`define CH_UPPER_REF 5'h1d
`define CH_LOWER_REF 5'h1e
`define CH_POWER_OFF 5'h1f
// conversion timing in converter clock cycles
`define CONV_TICKS 16
`define SAMPLE_TICKS 6
`endif

// ===== rtl/adc_pkg.sv
`default_nettype none
package adc_pkg;
   typedef logic [1:0] reg_addr_t;
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;
   typedef enum logic [1:0] {
      JUST_TRUNC8 = 2'b00,
      JUST_RIGHT = 2'b01,
      JUST_LEFT = 2'b10,
      JUST_LEFT_SIGNED = 2'b11
   } justify_t;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_CONV = 1'b1
   } conv_state_t;
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } result_t;
endpackage
`default_nettype wire

// ===== testbench/adc_conversion_control_props.sv
`timescale 1ns/1ps
`default_nettype none
module adc_cc_checker import adc_pkg::*; #(
   parameter int NUM_CH = 24,
   parameter int RES_BITS = 10
) (
   // clock, reset and register port
   input wire logic clk,
   input wire logic reset,
   input wire adc_pkg::bus_req_t bus_req,
   input wire logic [7:0] rd_data,
   input wire logic stop_mode,
   // pins and analog front end
   input wire logic [NUM_CH-1:0] port_out_data,
   input wire logic [NUM_CH-1:0] port_dir,
   input wire logic [NUM_CH-1:0] port_read_data,
   input wire logic [NUM_CH-1:0] pin_in,
   input wire logic [NUM_CH-1:0] pin_out,
   input wire logic [NUM_CH-1:0] pin_oe,
   input wire logic [NUM_CH-1:0] analog_select,
   input wire logic upper_ref_select,
   input wire logic lower_ref_select,
   input wire logic converter_on,
   input wire logic [RES_BITS-1:0] dac_code,
   input wire logic conv_irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////
   // saturates so an old write never looks recent
   logic [4:0] since_wr_ff;
   logic [4:0] nxt_since_wr;
   wire logic sc_wr = bus_req.wr && bus_req.addr == 2'h0;
   always_comb begin
      nxt_since_wr = since_wr_ff;
      if (sc_wr) nxt_since_wr = 5'h00;
      else if (since_wr_ff != 5'h1f) nxt_since_wr = since_wr_ff + 5'h01;
   end
   always_ff @(posedge clk) begin
      if (reset) since_wr_ff <= 5'h1f;
      else since_wr_ff <= nxt_since_wr;
   end
   ////////////////////////////////////////////////////////////////////////
   a_pin_override: assert property (
      !$past(reset) |-> pin_oe == ($past(port_dir) & ~analog_select)
      && pin_out == ($past(port_out_data) & ~analog_select))
      else $error("selected pin not taken from port logic");
   a_read_masked: assert property (
      !$past(reset) |-> port_read_data == ($past(pin_in) & ~analog_select))
      else $error("port read of selected pin not zero");
   a_mux_onehot: assert property (
      $onehot0({analog_select, upper_ref_select, lower_ref_select}))
      else $error("more than one converter input routed");
   a_off_no_mux: assert property (
      !converter_on |-> analog_select == '0 && !upper_ref_select
      && !lower_ref_select) else $error("input routed while powered off");
   a_reset_quiet: assert property (disable iff (1'b0)
      reset |=> !conv_irq && !converter_on && dac_code == '0
      && rd_data == 8'h00) else $error("reset left state active");
   a_stop_abort: assert property (
      stop_mode ##1 stop_mode |=> dac_code == '0 && !$rose(conv_irq))
      else $error("conversion ran during stop");
   // a write in the very cycle of an end still lets that end through
   a_conv_length: assert property (
      $rose(conv_irq) && since_wr_ff != 5'h00 |-> since_wr_ff >= 5'h10)
      else $error("conversion ended too early");
   a_off_clears_irq: assert property (
      sc_wr && bus_req.wdata[4:0] == 5'h1f |=> !conv_irq)
      else $error("status write left interrupt pending");
endmodule
bind adc_conversion_control adc_cc_checker #(.NUM_CH(NUM_CH),
   .RES_BITS(RES_BITS)) i_adc_cc_checker (.clk, .reset, .bus_req,
   .rd_data, .stop_mode, .port_out_data, .port_dir, .port_read_data,
   .pin_in, .pin_out, .pin_oe, .analog_select, .upper_ref_select,
   .lower_ref_select, .converter_on, .dac_code, .conv_irq);
`default_nettype wire

// ===== testbench/test_adc_conversion_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_conversion_control import adc_pkg::*;;
   logic clk = 1'b0;
   logic reset = 1'b1;
   bus_req_t bus_req = '0;
   logic osc_tick = 1'b0;
   logic stop_mode = 1'b0;
   logic [23:0] port_out_data = 24'ha5a5ff;
   logic [23:0] port_dir = 24'hffffff;
   logic [23:0] pin_in = 24'h3c3cff;
   logic [23:0] port_read_data, pin_out, pin_oe, analog_select;
   logic upper_ref_select, lower_ref_select, converter_on, conv_irq;
   logic [9:0] dac_code;
   logic [7:0] rd_data;
   logic [9:0] vin = 10'h000;
   logic [1:0] osc_cnt = 2'h0;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   // comparator stand-in; references override the pin voltage
   wire logic comp_above = upper_ref_select
      || (!lower_ref_select && vin >= dac_code);
   adc_conversion_control i_adc_conversion_control (.clk, .reset,
      .bus_req, .rd_data, .osc_tick, .stop_mode, .port_out_data,
      .port_dir, .port_read_data, .pin_in, .pin_out, .pin_oe,
      .analog_select, .upper_ref_select, .lower_ref_select,
      .converter_on, .dac_code, .comp_above, .conv_irq);
   always #10 clk = ~clk;
   always @(posedge clk) begin
      osc_cnt <= osc_cnt + 2'h1;
      osc_tick <= osc_cnt == 2'h0;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("ERROR %0t got %h exp %h", $time, got, exp);
         error_cnt++;
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk) bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk) bus_req <= '0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) bus_req <= '0;
      #1 d = rd_data;
   endtask
   task automatic wait_done();
      logic [7:0] s;
      s = 8'h00;
      for (int i = 0; i < 40 && !s[7]; i++) rd(2'h0, s);
      check(s[7], 1'b1);
   endtask
   task automatic res(input logic [15:0] exp);
      logic [7:0] h, l;
      rd(2'h1, h);
      rd(2'h2, l);
      check({h, l}, exp);
   endtask
   task automatic timed(input logic [7:0] cc, input int lo, input int hi);
      int n;
      logic [7:0] d;
      n = 0;
      wr(2'h3, cc);
      wr(2'h0, 8'h43);
      while (conv_irq !== 1'b1 && n < 400) begin
         @(posedge clk);
         #1 n++;
      end
      check(n >= lo && n <= hi, 1'b1);
      rd(2'h2, d);
      check(conv_irq, 1'b0);
   endtask
   function automatic logic [15:0] fmt(input logic [1:0] m,
      input logic [9:0] r);
      case (m)
         2'h0: fmt = {8'h00, r[9:2]};
         2'h1: fmt = {6'h00, r};
         2'h2: fmt = {r, 6'h00};
         default: fmt = {~r[9], r[8:0], 6'h00};
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] d;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      rd(2'h0, d);
      check(d, 8'h1f);
      rd(2'h3, d);
      check(d, 8'h04);
      check(converter_on, 1'b0);
      for (int k = 0; k < 5; k++) timed({k[2:0], 5'h14}, 16 << k, 17 << k);
      timed(8'hf4, 256, 272);
      timed(8'h04, 60, 68);
      check(analog_select, 24'h000008);
      check(pin_oe, 24'hfffff7);
      check(pin_out, 24'ha5a5f7);
      check(port_read_data, 24'h3c3cf7);
      check(converter_on, 1'b1);
      vin <= 10'h2b5;
      for (int m = 0; m < 4; m++) begin
         wr(2'h3, {4'h1, m[1:0], 2'h0});
         wr(2'h0, 8'h03);
         wait_done();
         res(fmt(m[1:0], 10'h2b5));
         rd(2'h0, d);
         check(d, 8'h03);
      end
      wr(2'h0, 8'h03);
      wait_done();
      rd(2'h1, d);
      vin <= 10'h0c3;
      wr(2'h0, 8'h03);
      wait_done();
      rd(2'h2, d);
      check(d, 8'h40);
      wr(2'h3, 8'h10);
      wr(2'h0, 8'h03);
      wait_done();
      rd(2'h1, d);
      vin <= 10'h3c0;
      wr(2'h0, 8'h03);
      wait_done();
      rd(2'h2, d);
      check(d, 8'hf0);
      wr(2'h3, 8'h14);
      vin <= 10'h111;
      wr(2'h0, 8'h23);
      wait_done();
      res(16'h0111);
      vin <= 10'h222;
      repeat (40) @(posedge clk);
      res(16'h0222);
      wr(2'h0, 8'h03);
      rd(2'h2, d);
      wait_done();
      res(16'h0222);
      repeat (40) @(posedge clk);
      rd(2'h0, d);
      check(d, 8'h03);
      wr(2'h0, 8'h1d);
      wait_done();
      res(16'h03ff);
      check({upper_ref_select, lower_ref_select}, 2'h2);
      wr(2'h0, 8'h1e);
      wait_done();
      res(16'h0000);
      check({upper_ref_select, lower_ref_select}, 2'h1);
      wr(2'h0, 8'h43);
      @(posedge clk) stop_mode <= 1'b1;
      repeat (30) @(posedge clk);
      #1 check({conv_irq, dac_code}, 11'h000);
      @(posedge clk) stop_mode <= 1'b0;
      repeat (20) @(posedge clk);
      #1 check(conv_irq, 1'b1);
      rd(2'h0, d);
      check(d, 8'h43);
      wr(2'h0, 8'h5f);
      #1 check(conv_irq, 1'b0);
      wr(2'h0, 8'h63);
      @(posedge clk) reset <= 1'b1;
      @(posedge clk) reset <= 1'b0;
      rd(2'h0, d);
      check(d, 8'h1f);
      repeat (20) @(posedge clk);
      #1 check({conv_irq, dac_code}, 11'h000);
      close_out();
   end
endmodule
`default_nettype wire
